/* File: src/hpsc_top.sv */
/*
 * Hub power and string configuration register bank: nine byte registers
 * written by the configuration loader, read back on the same port, and
 * fed to the descriptor logic and the per-port power settle timers.
 * Assumes one 125 MHz core clock, the self-powered sense pin arriving
 * asynchronously, and port power requests from hub logic on this clock.
 */
`timescale 1ns/1ns
module hpsc_top #(
	parameter int P_UNIT_CYCLES = hpsc_pkg::SETTLE_UNIT_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,

	// configuration byte port from the loader
	input wire logic i_cfg_wr,
	input wire logic i_cfg_rd,
	input wire logic [7:0] i_cfg_addr,
	input wire logic [7:0] i_cfg_wdata,
	input wire logic i_cfg_lock,
	output logic [7:0] o_cfg_rdata,
	output logic o_cfg_ack,
	output logic o_cfg_hit,

	// powering mode sense pin, asynchronous
	input wire logic i_self_powered,

	// values for the descriptor logic
	output logic [7:0] o_max_power,
	output logic [7:0] o_ctrl_current,
	output logic o_mode_flip,
	output logic o_self_mode,
	output logic [15:0] o_lang_id,
	output logic [7:0] o_maker_len,
	output logic [7:0] o_item_len,
	output logic o_len_over,

	// downstream port power sequencing
	input wire logic [hpsc_pkg::PORT_COUNT-1:0] i_port_power_req,
	output logic [hpsc_pkg::PORT_COUNT-1:0] o_port_power_stable
);

	localparam int NREG = hpsc_pkg::REG_COUNT;

	// register indices within the bank
	localparam int IX_SP_PWR = 0;
	localparam int IX_BP_PWR = 1;
	localparam int IX_SP_CUR = 2;
	localparam int IX_BP_CUR = 3;
	localparam int IX_SETTLE = 4;
	localparam int IX_LANG_UP = 5;
	localparam int IX_LANG_LO = 6;
	localparam int IX_MAKER = 7;
	localparam int IX_ITEM = 8;

	localparam logic [7:0] LAST_OFS = hpsc_pkg::OFS_ITEM_LEN;

	// storage for the bank
	logic [7:0] cfg_reg [NREG];

	// decode of the byte port
	logic [7:0] rel_addr;
	logic addr_hit;
	logic [3:0] reg_ix;
	logic wr_ok;
	logic [NREG-1:0] wr_sel;
	logic [7:0] rd_value;
	logic [7:0] rdata_next;

	// synchroniser for the powering mode pin
	logic mode_meta_reg;
	logic mode_sync_reg;

	// lengths beyond the descriptor limit
	logic maker_over;
	logic item_over;

	// byte port answers
	logic [7:0] rdata_reg;
	logic ack_reg;
	logic hit_reg;

	// descriptor outputs, registered
	logic [15:0] lang_reg;
	logic [7:0] maker_reg;
	logic [7:0] item_reg;
	logic over_reg;

	hpsc_desc_if desc ();

	// mode pin crosses in from outside; two flops before any use
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			mode_meta_reg <= 1'b0;
			mode_sync_reg <= 1'b0;
		end else begin
			mode_meta_reg <= i_self_powered;
			mode_sync_reg <= mode_meta_reg;
		end
	end

	// address decode; the bank is one contiguous run of bytes
	assign rel_addr = i_cfg_addr - hpsc_pkg::REG_BASE;
	assign addr_hit = (i_cfg_addr >= hpsc_pkg::REG_BASE) && (i_cfg_addr <= LAST_OFS);
	assign reg_ix = rel_addr[3:0];

	// writes stop once the hub is locked, so values cannot shift after attach
	assign wr_ok = i_cfg_wr && addr_hit && !i_cfg_lock;

	// one write select per register
	genvar g;
	generate
		for (g = 0; g < NREG; g = g + 1) begin : g_reg
			assign wr_sel[g] = wr_ok && (reg_ix == 4'(g));

			// each byte stores as written; reset value from the table
			always_ff @(posedge i_sys_clk or negedge i_resetn) begin
				if (!i_resetn) begin
					cfg_reg[g] <= hpsc_pkg::RST_VALUES[g];
				end else if (wr_sel[g]) begin
					cfg_reg[g] <= i_cfg_wdata;
				end
			end
		end
	endgenerate

	// read path; unmapped bytes answer with a fixed value
	assign rd_value = cfg_reg[reg_ix];
	assign rdata_next = addr_hit ? rd_value : hpsc_pkg::UNMAPPED_RDATA;

	// a read returns the byte stored before any write in the same cycle
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_reg <= hpsc_pkg::UNMAPPED_RDATA;
			ack_reg <= 1'b0;
			hit_reg <= 1'b0;
		end else begin
			if (i_cfg_rd) begin
				rdata_reg <= rdata_next;
			end
			ack_reg <= i_cfg_wr || i_cfg_rd;
			hit_reg <= (i_cfg_wr || i_cfg_rd) && addr_hit;
		end
	end

	assign o_cfg_rdata = rdata_reg;
	assign o_cfg_ack = ack_reg;
	assign o_cfg_hit = hit_reg;

	// power and current bytes travel to the selector
	assign desc.sp_max_power = cfg_reg[IX_SP_PWR];
	assign desc.bp_max_power = cfg_reg[IX_BP_PWR];
	assign desc.sp_ctrl_current = cfg_reg[IX_SP_CUR];
	assign desc.bp_ctrl_current = cfg_reg[IX_BP_CUR];
	assign desc.self_mode = mode_sync_reg;

	hpsc_desc_sel u_sel (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.desc(desc),
		.o_max_power(o_max_power),
		.o_ctrl_current(o_ctrl_current),
		.o_mode_flip(o_mode_flip)
	);

	assign o_self_mode = mode_sync_reg;

	// lengths are trusted from the loader; an overrange value is only flagged
	assign maker_over = cfg_reg[IX_MAKER] > hpsc_pkg::MAX_TEXT_LEN;
	assign item_over = cfg_reg[IX_ITEM] > hpsc_pkg::MAX_TEXT_LEN;

	// descriptor fields, registered for clean timing
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			lang_reg <= {hpsc_pkg::RST_LANG_UPPER, hpsc_pkg::RST_LANG_LOWER};
			maker_reg <= hpsc_pkg::RST_TEXT_LEN;
			item_reg <= hpsc_pkg::RST_TEXT_LEN;
			over_reg <= 1'b0;
		end else begin
			lang_reg <= {cfg_reg[IX_LANG_UP], cfg_reg[IX_LANG_LO]};
			maker_reg <= cfg_reg[IX_MAKER];
			item_reg <= cfg_reg[IX_ITEM];
			over_reg <= maker_over || item_over;
		end
	end

	assign o_lang_id = lang_reg;
	assign o_maker_len = maker_reg;
	assign o_item_len = item_reg;
	assign o_len_over = over_reg;

	// one settle timer per downstream port, all sharing the settle byte
	generate
		for (g = 0; g < hpsc_pkg::PORT_COUNT; g = g + 1) begin : g_port
			hpsc_settle_timer #(
				.P_UNIT_CYCLES(P_UNIT_CYCLES)
			) u_settle (
				.i_sys_clk(i_sys_clk),
				.i_resetn(i_resetn),
				.i_power_req(i_port_power_req[g]),
				.i_settle_units(cfg_reg[IX_SETTLE]),
				.o_stable(o_port_power_stable[g])
			);
		end
	endgenerate

endmodule : hpsc_top

/* File: common/hpsc_pkg.sv */
/*
 * Shared constants for the hub power and string configuration register bank:
 * register offsets, reset values, limits and settle timing.
 * Assumes a 125 MHz core clock and byte-wide configuration writes from a
 * serial EEPROM loader or an SMBus slave sitting in front of this block.
 */
package hpsc_pkg;

	// register map, one byte each, contiguous from the base
	localparam logic [7:0] REG_BASE = 8'h0C;
	localparam int REG_COUNT = 9;
	localparam logic [7:0] OFS_SP_MAX_POWER = 8'h0C;
	localparam logic [7:0] OFS_BP_MAX_POWER = 8'h0D;
	localparam logic [7:0] OFS_SP_CTRL_CURRENT = 8'h0E;
	localparam logic [7:0] OFS_BP_CTRL_CURRENT = 8'h0F;
	localparam logic [7:0] OFS_SETTLE_TIME = 8'h10;
	localparam logic [7:0] OFS_LANG_UPPER = 8'h11;
	localparam logic [7:0] OFS_LANG_LOWER = 8'h12;
	localparam logic [7:0] OFS_MAKER_LEN = 8'h13;
	localparam logic [7:0] OFS_ITEM_LEN = 8'h14;

	// reset values; only the controller currents are fixed, others start at zero
	localparam logic [7:0] RST_SP_MAX_POWER = 8'h00;
	localparam logic [7:0] RST_BP_MAX_POWER = 8'h00;
	localparam logic [7:0] RST_CTRL_CURRENT = 8'h32;
	localparam logic [7:0] RST_SETTLE_TIME = 8'h00;
	localparam logic [7:0] RST_LANG_UPPER = 8'h00;
	localparam logic [7:0] RST_LANG_LOWER = 8'h00;
	localparam logic [7:0] RST_TEXT_LEN = 8'h00;
	localparam logic [7:0] RST_VALUES [REG_COUNT] = '{
		RST_SP_MAX_POWER, RST_BP_MAX_POWER, RST_CTRL_CURRENT,
		RST_CTRL_CURRENT, RST_SETTLE_TIME, RST_LANG_UPPER,
		RST_LANG_LOWER, RST_TEXT_LEN, RST_TEXT_LEN};

	// answer to a read outside the bank
	localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

	// longest descriptor text in characters
	localparam logic [7:0] MAX_TEXT_LEN = 8'h1F;

	// settle timing: one step of the settle time byte
	localparam int CLK_PERIOD_NS = 8;
	localparam int SETTLE_UNIT_NS = 2000000;
	localparam int SETTLE_UNIT_CYCLES = SETTLE_UNIT_NS / CLK_PERIOD_NS;

	// downstream ports served by the settle timers
	localparam int PORT_COUNT = 7;

endpackage : hpsc_pkg

/* File: common/hpsc_desc_if.sv */
/*
 * Carries the raw power and current bytes plus the powering mode from the
 * register bank to the descriptor value selector.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ns
interface hpsc_desc_if;
	logic [7:0] sp_max_power;
	logic [7:0] bp_max_power;
	logic [7:0] sp_ctrl_current;
	logic [7:0] bp_ctrl_current;
	logic self_mode;

	modport src (output sp_max_power, bp_max_power, sp_ctrl_current,
		bp_ctrl_current, self_mode);
	modport dst (input sp_max_power, bp_max_power, sp_ctrl_current,
		bp_ctrl_current, self_mode);
endinterface : hpsc_desc_if

/* File: src/hpsc_desc_sel.sv */
/*
 * Picks the self-powered or bus-powered power and current bytes for the
 * hub descriptors and flags a change of powering mode.
 * Assumes the mode bit is already synchronised to the core clock.
 */
`timescale 1ns/1ns
module hpsc_desc_sel (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	hpsc_desc_if.dst desc,
	output logic [7:0] o_max_power,
	output logic [7:0] o_ctrl_current,
	output logic o_mode_flip
);
	logic [7:0] power_next;
	logic [7:0] current_next;
	logic mode_reg;

	// selection by the mode in effect now
	assign power_next = desc.self_mode ? desc.sp_max_power : desc.bp_max_power;
	assign current_next = desc.self_mode ? desc.sp_ctrl_current : desc.bp_ctrl_current;

	// registered so the descriptor logic sees clean bytes
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_max_power <= hpsc_pkg::RST_BP_MAX_POWER; // mode resets to bus-powered
			o_ctrl_current <= hpsc_pkg::RST_CTRL_CURRENT;
			mode_reg <= 1'b0;
			o_mode_flip <= 1'b0;
		end else begin
			o_max_power <= power_next;
			o_ctrl_current <= current_next;
			mode_reg <= desc.self_mode;
			o_mode_flip <= mode_reg ^ desc.self_mode; // descriptors must be refetched
		end
	end
endmodule : hpsc_desc_sel

/* File: src/hpsc_settle_timer.sv */
/*
 * One downstream port's power-on settle timer: after power is requested,
 * waits the programmed number of 2 ms steps, then reports power stable.
 * Assumes the request is a level from hub port logic on the core clock.
 */
`timescale 1ns/1ns
module hpsc_settle_timer #(
	parameter int P_UNIT_CYCLES = hpsc_pkg::SETTLE_UNIT_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_power_req,
	input wire logic [7:0] i_settle_units,
	output logic o_stable
);
	typedef enum logic [1:0] {ST_OFF, ST_RAMP, ST_ON} hpsc_settle_t;
	hpsc_settle_t state_reg;
	hpsc_settle_t state_next;
	logic [31:0] cyc_reg;
	logic [7:0] units_reg;
	logic unit_done;
	logic ramp_done;

	localparam logic [31:0] UNIT_LAST = 32'(P_UNIT_CYCLES - 1);

	assign unit_done = (cyc_reg == UNIT_LAST);
	assign ramp_done = (units_reg == 8'h00);

	// sequence: off, counting, stable; dropping the request ends it at once
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_OFF: if (i_power_req) state_next = ST_RAMP;
			ST_RAMP: if (!i_power_req) state_next = ST_OFF;
				else if (ramp_done) state_next = ST_ON;
			ST_ON: if (!i_power_req) state_next = ST_OFF;
		endcase
	end

	// settle byte latched at start, a later write does not stretch a ramp
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= ST_OFF;
			cyc_reg <= 32'h0000_0000;
			units_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			if (state_reg != ST_RAMP || unit_done)
				cyc_reg <= 32'h0000_0000;
			else
				cyc_reg <= cyc_reg + 32'h0000_0001;
			if (state_reg == ST_OFF)
				units_reg <= i_settle_units;
			else if (state_reg == ST_RAMP && unit_done && !ramp_done)
				units_reg <= units_reg - 8'h01;
		end
	end

	assign o_stable = (state_reg == ST_ON);
endmodule : hpsc_settle_timer

/* File: verif/hpsc_top_props.sv */
/*
 * Port checker for the hub power and string configuration bank.
 * Assumes the top's single core clock and its active-low reset.
 */
`timescale 1ns/1ns
module hpsc_top_props #(
	parameter int P_UNIT_CYCLES = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_cfg_wr,
	input wire logic i_cfg_rd,
	input wire logic [7:0] i_cfg_addr,
	input wire logic [7:0] i_cfg_wdata,
	input wire logic i_cfg_lock,
	input wire logic [7:0] o_cfg_rdata,
	input wire logic o_cfg_ack,
	input wire logic o_cfg_hit,
	input wire logic i_self_powered,
	input wire logic o_self_mode,
	input wire logic o_mode_flip,
	input wire logic [15:0] o_lang_id,
	input wire logic [7:0] o_maker_len,
	input wire logic o_len_over,
	input wire logic [hpsc_pkg::PORT_COUNT-1:0] i_port_power_req,
	input wire logic [hpsc_pkg::PORT_COUNT-1:0] o_port_power_stable
);
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_resetn);
	// accepted write and mapped address, shared by several checks
	wire wr_ok = i_cfg_wr && !i_cfg_lock;
	wire in_map = i_cfg_addr >= 8'h0C && i_cfg_addr <= 8'h14;

	a_ack_after_req: assert property ((i_cfg_wr || i_cfg_rd) |=> o_cfg_ack)
		else $error("missing answer to a byte request");
	a_hit_on_map: assert property ((i_cfg_wr || i_cfg_rd) |=> o_cfg_hit == $past(in_map))
		else $error("hit flag does not match address");
	a_unmapped_zero: assert property ((i_cfg_rd && !in_map) |=> o_cfg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_lang_upper: assert property ((wr_ok && i_cfg_addr == 8'h11) |=> ##1
		o_lang_id[15:8] == $past(i_cfg_wdata, 2)) else $error("language upper byte wrong");
	a_lang_lower: assert property ((wr_ok && i_cfg_addr == 8'h12) |=> ##1
		o_lang_id[7:0] == $past(i_cfg_wdata, 2)) else $error("language lower byte wrong");
	a_lock_drops: assert property ((i_cfg_wr && i_cfg_lock) |=> ##1 $stable(o_lang_id))
		else $error("locked write changed a value");
	a_maker_len: assert property ((wr_ok && i_cfg_addr == 8'h13) |=> ##1
		o_maker_len == $past(i_cfg_wdata, 2)) else $error("maker length not passed on");
	a_len_flag: assert property ((wr_ok && i_cfg_addr == 8'h14 && i_cfg_wdata > 8'h1F)
		|=> ##[1:2] o_len_over) else $error("length over 31 not flagged");
	a_mode_sync: assert property ($rose(o_self_mode) |-> $past(i_self_powered, 2))
		else $error("mode rose without the pin");
	a_stable_drop: assert property (1'b1 |=>
		(o_port_power_stable & ~$past(i_port_power_req)) == '0) else $error("stable held");
	a_flip_pulse: assert property ($changed(o_self_mode) |=> o_mode_flip)
		else $error("mode change not flagged");
	a_flip_quiet: assert property (!$changed(o_self_mode) |=> !o_mode_flip)
		else $error("mode flag without a mode change");

	cover property (i_cfg_rd && !in_map);
	cover property ($rose(o_port_power_stable[0]));
	cover property ($rose(o_len_over));
	cover property ($rose(o_mode_flip));
endmodule : hpsc_top_props

bind hpsc_top hpsc_top_props #(.P_UNIT_CYCLES(P_UNIT_CYCLES)) u_props (
	.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd),
	.i_cfg_addr(i_cfg_addr), .i_cfg_wdata(i_cfg_wdata), .i_cfg_lock(i_cfg_lock),
	.o_cfg_rdata(o_cfg_rdata), .o_cfg_ack(o_cfg_ack), .o_cfg_hit(o_cfg_hit),
	.i_self_powered(i_self_powered), .o_self_mode(o_self_mode), .o_mode_flip(o_mode_flip),
	.o_lang_id(o_lang_id),
	.o_maker_len(o_maker_len), .o_len_over(o_len_over),
	.i_port_power_req(i_port_power_req), .o_port_power_stable(o_port_power_stable)
);

/* File: verif/hpsc_loader_model.sv */
/*
 * Model of the configuration loader in front of the byte port.
 * Assumes the answer arrives exactly one cycle after each request.
 */
`timescale 1ns/1ns
module hpsc_loader_model (
	input wire logic i_sys_clk,
	input wire logic i_ack,
	input wire logic i_hit,
	input wire logic [7:0] i_rdata,
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	logic break_len = 1'b0;
	logic last_ack;
	logic last_hit;
	logic [7:0] last_rdata;
	// quiet port at time zero
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	// one byte access; released lines show the inverse so stale data never matches
	task automatic access(input logic rd, input logic [7:0] a, input logic [7:0] d);
		if (!rd && !break_len && (a == 8'h13 || a == 8'h14) && d > 8'h1F) d = 8'h1F;
		@(posedge i_sys_clk);
		o_wr <= !rd;
		o_rd <= rd;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_sys_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
		#1;
		last_ack = i_ack;
		last_hit = i_hit;
		last_rdata = i_rdata;
	endtask : access
endmodule : hpsc_loader_model

/* File: verif/tb_top.sv */
/*
 * Bench for the configuration bank: a reference array of the nine bytes.
 * Assumes a settle step shortened to 4 cycles.
 */
`timescale 1ns/1ns
module tb_top;
	localparam int UNIT = 4;
	logic sys_clk = 1'b0, resetn = 1'b0, lock = 1'b0, self_pw = 1'b0;
	logic [6:0] preq = 7'h00;
	logic wr, rd, ack, hit, over;
	logic [7:0] addr, wdata, rdata, maxp, curr, mlen, ilen;
	logic [15:0] lang;
	logic [6:0] stab;
	logic [31:0] rng = 32'h0000003A;
	int fails = 0, checked = 0, cnt;
	int ref_reg [9] = '{0, 0, 50, 50, 0, 0, 0, 0, 0};
	int ns [3] = '{0, 1, 3};
	// core clock, 8 ns
	initial forever #4 sys_clk = ~sys_clk;
	hpsc_top #(.P_UNIT_CYCLES(UNIT)) u_dut (.i_sys_clk(sys_clk), .i_resetn(resetn),
		.i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_wdata(wdata),
		.i_cfg_lock(lock), .o_cfg_rdata(rdata), .o_cfg_ack(ack), .o_cfg_hit(hit),
		.i_self_powered(self_pw), .o_max_power(maxp), .o_ctrl_current(curr),
		.o_mode_flip(), .o_self_mode(), .o_lang_id(lang), .o_maker_len(mlen),
		.o_item_len(ilen), .o_len_over(over), .i_port_power_req(preq),
		.o_port_power_stable(stab));
	hpsc_loader_model u_ldr (.i_sys_clk(sys_clk), .i_ack(ack), .i_hit(hit),
		.i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
	function automatic logic [7:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[7:0];
	endfunction : rnd
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step
	task automatic chk(input logic [15:0] got, input int exp);
		checked++;
		if (got !== exp[15:0]) begin
			fails++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic results();
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	task automatic rdchk(input logic [7:0] a);
		logic m;
		m = a >= 8'h0C && a <= 8'h14;
		u_ldr.access(1'b1, a, 8'h00);
		chk(16'(u_ldr.last_ack), 1);
		chk(16'(u_ldr.last_hit), int'(m));
		chk(16'(u_ldr.last_rdata), m ? ref_reg[a - 8'h0C] : 0);
	endtask : rdchk
	// the loader never sends a length above 31 unless told to
	task automatic wrref(input logic [7:0] a, input logic [7:0] d);
		if ((a == 8'h13 || a == 8'h14) && !u_ldr.break_len && d > 8'h1F) d = 8'h1F;
		u_ldr.access(1'b0, a, d);
		if (!lock && a >= 8'h0C && a <= 8'h14) ref_reg[a - 8'h0C] = d;
	endtask : wrref
	task automatic outchk();
		chk(16'(maxp), self_pw ? ref_reg[0] : ref_reg[1]);
		chk(16'(curr), self_pw ? ref_reg[2] : ref_reg[3]);
		chk(lang, ref_reg[5] * 256 + ref_reg[6]);
		chk(16'(mlen), ref_reg[7]);
		chk(16'(ilen), ref_reg[8]);
	endtask : outchk
	// reset, random fills in both modes, lock, length flag, settle timing
	initial begin
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		for (int a = 8'h0B; a <= 8'h15; a++) rdchk(a[7:0]);
		step(1);
		outchk();
		for (int i = 0; i < 4; i++) begin
			for (int a = 8'h0C; a <= 8'h14; a++) wrref(a[7:0], rnd());
			@(posedge sys_clk);
			self_pw <= i[0];
			step(5);
			outchk();
			for (int a = 8'h0C; a <= 8'h14; a++) rdchk(a[7:0]);
		end
		@(posedge sys_clk);
		lock <= 1'b1;
		wrref(8'h11, 8'hA5);
		@(posedge sys_clk);
		lock <= 1'b0;
		rdchk(8'h11);
		u_ldr.break_len = 1'b1;
		for (int a = 8'h13; a <= 8'h14; a++) begin
			wrref(a[7:0], 8'h20);
			step(2);
			chk(16'(over), 1);
			wrref(a[7:0], 8'h1F);
			step(2);
			chk(16'(over), 0);
		end
		u_ldr.break_len = 1'b0;
		foreach (ns[k]) begin
			wrref(8'h10, ns[k][7:0]);
			@(posedge sys_clk);
			preq <= 7'h7F;
			cnt = 0;
			do begin
				step(1);
				cnt++;
			end while (stab !== 7'h7F && cnt < 100);
			if (cnt >= 100) begin
				fails++;
				results();
			end
			chk(16'(cnt), 2 + UNIT * ns[k]);
			@(posedge sys_clk);
			preq <= 7'h00;
			step(2);
			chk(16'(stab), 0);
		end
		results();
	end
endmodule : tb_top
